// ===== rtl/sfb_spi_buffers.sv
// Behaviour
// - double speed bit doubles serial clock rate
// - normal rates divide by 4, 16, 64, 128
// - double rates divide by 2, 8, 32, 64
// - one data port: write transmits, read receives
// - rx empty high while nothing buffered
// - writing one at rx empty resets rx pointer
// - both empty bits also reset bit pointer
// - data read returns entry, increments rx pointer
// - tx full at four bytes, raises interrupt flag
// - tx empty high when nothing left unsent
// - data write stores byte, increments tx pointer
// - writing one at tx empty resets tx pointer
// - transfer end sets flag; enables gate interrupt
//
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps
`default_nettype none

module sfb_spi_buffers
(
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   // apb slave
   input wire logic [11:0] paddr_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // interrupt
   input wire logic global_irq_enable_in,
   output logic irq_out,
   // serial link
   output logic serial_clock_pin_out,
   output logic mosi_out,
   input wire logic miso_in,
   output logic select_n_out
);

   sfb_pkg::sfb_ctrl_s ctrl_ff, nxt_ctrl;
   sfb_pkg::sfb_state_e state_ff, nxt_state;
   logic dual_ff, nxt_dual;
   logic dbl_ff, nxt_dbl;
   logic wcol_ff, nxt_wcol;
   logic stat_armed_ff, nxt_stat_armed;
   logic [sfb_pkg::IRQ_W-1:0] irq_sts_ff, nxt_irq_sts;
   logic [sfb_pkg::IRQ_W-1:0] irq_mask_ff, nxt_irq_mask;
   logic [7:0] tx_buf_ff [0:3];
   logic [7:0] nxt_tx_buf [0:3];
   logic [7:0] rx_buf_ff [0:3];
   logic [7:0] nxt_rx_buf [0:3];
   logic [1:0] tx_wp_ff, nxt_tx_wp;
   logic [1:0] tx_sp_ff, nxt_tx_sp;
   logic [2:0] tx_cnt_ff, nxt_tx_cnt;
   logic [1:0] rx_wp_ff, nxt_rx_wp;
   logic [1:0] rx_rp_ff, nxt_rx_rp;
   logic [2:0] rx_cnt_ff, nxt_rx_cnt;
   logic [6:0] div_ff, nxt_div;
   logic [3:0] edge_ff, nxt_edge;
   logic [3:0] bit_ptr_ff, nxt_bit_ptr;
   logic [7:0] tx_sh_ff, nxt_tx_sh;
   logic [7:0] rx_sh_ff, nxt_rx_sh;
   logic sck_ff, nxt_sck;
   logic [7:0] prdata_ff, nxt_prdata;

   logic [7:0] idx;
   logic mapped;
   logic wr_done;
   logic rd_done;
   logic setup;
   logic [7:0] wbyte;
   logic [6:0] half;
   logic [7:0] buf_status;
   logic [7:0] status_byte;

   assign idx = paddr_in[9:2];
   assign mapped = (paddr_in[11:10] == 2'h0) && (paddr_in[1:0] == 2'h0) &&
                   (idx == sfb_pkg::IDX_BUF_STATUS || idx == sfb_pkg::IDX_CTRL ||
                    idx == sfb_pkg::IDX_STATUS || idx == sfb_pkg::IDX_DATA ||
                    idx == sfb_pkg::IDX_IRQ_STATUS || idx == sfb_pkg::IDX_IRQ_MASK);
   assign setup = psel_in && !penable_in;
   assign wr_done = psel_in && penable_in && pwrite_in && mapped;
   assign rd_done = psel_in && penable_in && !pwrite_in && mapped;
   assign wbyte = pwdata_in[7:0];
   assign half = sfb_pkg::half_div(dbl_ff, ctrl_ff.rate_sel);

   always_comb
   begin
      buf_status = 8'h00;
      buf_status[sfb_pkg::BIT_RX_FULL] = (rx_cnt_ff == sfb_pkg::BUF_DEPTH);
      buf_status[sfb_pkg::BIT_RX_EMPTY] = (rx_cnt_ff == 3'h0);
      buf_status[sfb_pkg::BIT_RX_PTR_LO +: 2] = rx_rp_ff;
      buf_status[sfb_pkg::BIT_TX_FULL] = (tx_cnt_ff == sfb_pkg::BUF_DEPTH);
      buf_status[sfb_pkg::BIT_TX_EMPTY] = (tx_cnt_ff == 3'h0) && (state_ff != sfb_pkg::SFB_RUN);
      buf_status[sfb_pkg::BIT_TX_PTR_LO +: 2] = tx_wp_ff;
      status_byte = 8'h00;
      status_byte[sfb_pkg::BIT_DONE] = irq_sts_ff[sfb_pkg::IRQ_DONE];
      status_byte[sfb_pkg::BIT_WCOL] = wcol_ff;
      status_byte[sfb_pkg::BIT_DUAL] = dual_ff;
      status_byte[sfb_pkg::BIT_DOUBLE] = dbl_ff;
   end

   always_comb
   begin
      logic [sfb_pkg::IRQ_W-1:0] irq_set;
      logic leading;
      logic sample;
      logic rx_push;
      logic [7:0] rx_new;
      irq_set = '0;
      leading = 1'b0;
      sample = 1'b0;
      rx_push = 1'b0;
      rx_new = rx_sh_ff;
      nxt_ctrl = ctrl_ff;
      nxt_state = state_ff;
      nxt_dual = dual_ff;
      nxt_dbl = dbl_ff;
      nxt_wcol = wcol_ff;
      nxt_stat_armed = stat_armed_ff;
      nxt_irq_sts = irq_sts_ff;
      nxt_irq_mask = irq_mask_ff;
      nxt_tx_buf = tx_buf_ff;
      nxt_rx_buf = rx_buf_ff;
      nxt_tx_wp = tx_wp_ff;
      nxt_tx_sp = tx_sp_ff;
      nxt_tx_cnt = tx_cnt_ff;
      nxt_rx_wp = rx_wp_ff;
      nxt_rx_rp = rx_rp_ff;
      nxt_rx_cnt = rx_cnt_ff;
      nxt_div = div_ff;
      nxt_edge = edge_ff;
      nxt_bit_ptr = bit_ptr_ff;
      nxt_tx_sh = tx_sh_ff;
      nxt_rx_sh = rx_sh_ff;
      nxt_sck = sck_ff;
      nxt_prdata = prdata_ff;

      // read data is latched in the setup phase so the access phase needs no wait
      if (setup)
      begin
         case (idx)
            sfb_pkg::IDX_BUF_STATUS: nxt_prdata = buf_status;
            sfb_pkg::IDX_CTRL: nxt_prdata = ctrl_ff;
            sfb_pkg::IDX_STATUS: nxt_prdata = status_byte;
            sfb_pkg::IDX_DATA: nxt_prdata = rx_buf_ff[rx_rp_ff];
            sfb_pkg::IDX_IRQ_STATUS: nxt_prdata = {5'h00, irq_sts_ff};
            sfb_pkg::IDX_IRQ_MASK: nxt_prdata = {5'h00, irq_mask_ff};
            default: nxt_prdata = 8'h00;
         endcase
      end

      // serial engine, master only
      case (state_ff)
         sfb_pkg::SFB_IDLE:
         begin
            nxt_sck = ctrl_ff.cpol;
            if (ctrl_ff.enable && ctrl_ff.master && tx_cnt_ff != 3'h0)
            begin
               nxt_tx_sh = tx_buf_ff[tx_sp_ff];
               nxt_tx_sp = tx_sp_ff + 2'h1;
               nxt_tx_cnt = tx_cnt_ff - 3'h1;
               nxt_div = 7'h00;
               nxt_edge = 4'h0;
               nxt_bit_ptr = 4'h0;
               nxt_state = sfb_pkg::SFB_RUN;
            end
         end
         sfb_pkg::SFB_RUN:
         begin
            if (!ctrl_ff.enable)
            begin
               nxt_state = sfb_pkg::SFB_IDLE;
            end
            else if (div_ff == half - 7'h01)
            begin
               nxt_div = 7'h00;
               nxt_sck = ~sck_ff;
               leading = ~edge_ff[0];
               sample = ctrl_ff.cpha ? ~leading : leading;
               if (sample)
               begin
                  rx_new = ctrl_ff.lsb_first ? {miso_in, rx_sh_ff[7:1]} : {rx_sh_ff[6:0], miso_in};
                  nxt_rx_sh = rx_new;
                  nxt_bit_ptr = bit_ptr_ff + 4'h1;
               end
               else if (!(ctrl_ff.cpha && edge_ff == 4'h0))
               begin
                  // in phase-one mode the first leading edge only presents the first bit
                  nxt_tx_sh = ctrl_ff.lsb_first ? {1'b0, tx_sh_ff[7:1]} : {tx_sh_ff[6:0], 1'b0};
               end
               nxt_edge = edge_ff + 4'h1;
               if (edge_ff == sfb_pkg::LAST_EDGE)
               begin
                  rx_push = 1'b1;
                  irq_set[sfb_pkg::IRQ_DONE] = 1'b1;
                  nxt_state = sfb_pkg::SFB_IDLE;
               end
            end
            else
            begin
               nxt_div = div_ff + 7'h01;
            end
         end
         default: nxt_state = sfb_pkg::SFB_IDLE;
      endcase

      // received byte enters the queue; a byte arriving while full is dropped
      if (rx_push && nxt_rx_cnt != sfb_pkg::BUF_DEPTH)
      begin
         nxt_rx_buf[rx_wp_ff] = rx_new;
         nxt_rx_wp = rx_wp_ff + 2'h1;
         nxt_rx_cnt = nxt_rx_cnt + 3'h1;
         if (nxt_rx_cnt == sfb_pkg::BUF_DEPTH)
         begin
            irq_set[sfb_pkg::IRQ_RX_FULL] = 1'b1;
         end
      end

      if (rd_done && idx == sfb_pkg::IDX_DATA)
      begin
         nxt_rx_rp = rx_rp_ff + 2'h1;
         if (nxt_rx_cnt != 3'h0)
         begin
            nxt_rx_cnt = nxt_rx_cnt - 3'h1;
         end
      end

      if (wr_done)
      begin
         case (idx)
            sfb_pkg::IDX_CTRL: nxt_ctrl = sfb_pkg::sfb_ctrl_s'(wbyte);
            sfb_pkg::IDX_STATUS:
            begin
               nxt_dual = wbyte[sfb_pkg::BIT_DUAL];
               nxt_dbl = wbyte[sfb_pkg::BIT_DOUBLE];
            end
            sfb_pkg::IDX_DATA:
            begin
               if (nxt_tx_cnt == sfb_pkg::BUF_DEPTH)
               begin
                  nxt_wcol = 1'b1;
               end
               else
               begin
                  nxt_tx_buf[tx_wp_ff] = wbyte;
                  nxt_tx_wp = tx_wp_ff + 2'h1;
                  nxt_tx_cnt = nxt_tx_cnt + 3'h1;
                  if (nxt_tx_cnt == sfb_pkg::BUF_DEPTH)
                  begin
                     irq_set[sfb_pkg::IRQ_TX_FULL] = 1'b1;
                     irq_set[sfb_pkg::IRQ_DONE] = 1'b1;
                  end
               end
            end
            sfb_pkg::IDX_BUF_STATUS:
            begin
               if (wbyte[sfb_pkg::BIT_RX_EMPTY])
               begin
                  nxt_rx_rp = 2'h0;
                  nxt_rx_wp = 2'h0;
                  nxt_rx_cnt = 3'h0;
               end
               if (wbyte[sfb_pkg::BIT_RX_EMPTY] && wbyte[sfb_pkg::BIT_TX_EMPTY])
               begin
                  nxt_bit_ptr = 4'h0;
                  nxt_rx_sh = 8'h00;
               end
               if (wbyte[sfb_pkg::BIT_TX_EMPTY])
               begin
                  nxt_tx_wp = 2'h0;
                  nxt_tx_sp = 2'h0;
                  nxt_tx_cnt = 3'h0;
               end
            end
            sfb_pkg::IDX_IRQ_STATUS: nxt_irq_sts = irq_sts_ff & ~wbyte[sfb_pkg::IRQ_W-1:0];
            sfb_pkg::IDX_IRQ_MASK: nxt_irq_mask = wbyte[sfb_pkg::IRQ_W-1:0];
            default: nxt_irq_mask = irq_mask_ff;
         endcase
      end

      // status read followed by a data access clears done and collision
      if (wr_done || rd_done)
      begin
         if (stat_armed_ff && idx == sfb_pkg::IDX_DATA)
         begin
            nxt_irq_sts[sfb_pkg::IRQ_DONE] = 1'b0;
            if (!(wr_done && nxt_tx_cnt == sfb_pkg::BUF_DEPTH && tx_cnt_ff == sfb_pkg::BUF_DEPTH))
            begin
               nxt_wcol = 1'b0;
            end
         end
         nxt_stat_armed = rd_done && idx == sfb_pkg::IDX_STATUS;
      end

      // a new event wins over a clear in the same cycle
      nxt_irq_sts = nxt_irq_sts | irq_set;
   end

   always_ff @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         ctrl_ff <= sfb_pkg::sfb_ctrl_s'(sfb_pkg::CTRL_RST);
         state_ff <= sfb_pkg::SFB_IDLE;
         dual_ff <= 1'b0;
         dbl_ff <= 1'b0;
         wcol_ff <= 1'b0;
         stat_armed_ff <= 1'b0;
         irq_sts_ff <= '0;
         irq_mask_ff <= sfb_pkg::IRQ_MASK_RST;
         for (int i = 0; i < 4; i++)
         begin
            tx_buf_ff[i] <= sfb_pkg::DATA_RST;
            rx_buf_ff[i] <= sfb_pkg::DATA_RST;
         end
         tx_wp_ff <= 2'h0;
         tx_sp_ff <= 2'h0;
         tx_cnt_ff <= 3'h0;
         rx_wp_ff <= 2'h0;
         rx_rp_ff <= 2'h0;
         rx_cnt_ff <= 3'h0;
         div_ff <= 7'h00;
         edge_ff <= 4'h0;
         bit_ptr_ff <= 4'h0;
         tx_sh_ff <= 8'h00;
         rx_sh_ff <= 8'h00;
         sck_ff <= 1'b0;
         prdata_ff <= 8'h00;
      end
      else
      begin
         ctrl_ff <= nxt_ctrl;
         state_ff <= nxt_state;
         dual_ff <= nxt_dual;
         dbl_ff <= nxt_dbl;
         wcol_ff <= nxt_wcol;
         stat_armed_ff <= nxt_stat_armed;
         irq_sts_ff <= nxt_irq_sts;
         irq_mask_ff <= nxt_irq_mask;
         tx_buf_ff <= nxt_tx_buf;
         rx_buf_ff <= nxt_rx_buf;
         tx_wp_ff <= nxt_tx_wp;
         tx_sp_ff <= nxt_tx_sp;
         tx_cnt_ff <= nxt_tx_cnt;
         rx_wp_ff <= nxt_rx_wp;
         rx_rp_ff <= nxt_rx_rp;
         rx_cnt_ff <= nxt_rx_cnt;
         div_ff <= nxt_div;
         edge_ff <= nxt_edge;
         bit_ptr_ff <= nxt_bit_ptr;
         tx_sh_ff <= nxt_tx_sh;
         rx_sh_ff <= nxt_rx_sh;
         sck_ff <= nxt_sck;
         prdata_ff <= nxt_prdata;
      end
   end

   assign prdata_out = {24'h000000, prdata_ff};
   assign pready_out = psel_in && penable_in;
   assign pslverr_out = psel_in && penable_in && !mapped;
   // done only reaches the pin when the unit's own interrupt enable is set too
   assign irq_out = global_irq_enable_in &&
                    |(irq_sts_ff & irq_mask_ff & {2'b11, ctrl_ff.int_en});
   assign serial_clock_pin_out = sck_ff;
   assign mosi_out = ctrl_ff.lsb_first ? tx_sh_ff[0] : tx_sh_ff[7];
   assign select_n_out = (state_ff != sfb_pkg::SFB_RUN);

endmodule : sfb_spi_buffers

`default_nettype wire

// ===== rtl/sfb_pkg.sv
package sfb_pkg;

   // register indices; the byte address on the bus is four times the index
   localparam logic [7:0] IDX_BUF_STATUS = 8'h39;
   localparam logic [7:0] IDX_CTRL = 8'h4c;
   localparam logic [7:0] IDX_STATUS = 8'h4d;
   localparam logic [7:0] IDX_DATA = 8'h4e;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h50;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h51;

   // buffer status fields
   localparam int BIT_RX_FULL = 7;
   localparam int BIT_RX_EMPTY = 6;
   localparam int BIT_RX_PTR_LO = 4;
   localparam int BIT_TX_FULL = 3;
   localparam int BIT_TX_EMPTY = 2;
   localparam int BIT_TX_PTR_LO = 0;

   // status register fields
   localparam int BIT_DONE = 7;
   localparam int BIT_WCOL = 6;
   localparam int BIT_DUAL = 2;
   localparam int BIT_DOUBLE = 0;

   // interrupt status and mask fields
   localparam int IRQ_DONE = 0;
   localparam int IRQ_RX_FULL = 1;
   localparam int IRQ_TX_FULL = 2;
   localparam int IRQ_W = 3;

   // reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

   // buffer depth and bit timing
   localparam logic [2:0] BUF_DEPTH = 3'h4;
   localparam logic [3:0] LAST_EDGE = 4'hf;

   // clock divisors of the system clock
   localparam logic [7:0] DIV_NORM_0 = 8'h04;
   localparam logic [7:0] DIV_NORM_1 = 8'h10;
   localparam logic [7:0] DIV_NORM_2 = 8'h40;
   localparam logic [7:0] DIV_NORM_3 = 8'h80;
   localparam logic [7:0] DIV_FAST_0 = 8'h02;
   localparam logic [7:0] DIV_FAST_1 = 8'h08;
   localparam logic [7:0] DIV_FAST_2 = 8'h20;
   localparam logic [7:0] DIV_FAST_3 = 8'h40;

   typedef struct packed {
      logic int_en;
      logic enable;
      logic lsb_first;
      logic master;
      logic cpol;
      logic cpha;
      logic [1:0] rate_sel;
   } sfb_ctrl_s;

   typedef enum logic {SFB_IDLE, SFB_RUN} sfb_state_e;

   // system clock cycles per half period of the serial clock
   function automatic logic [6:0] half_div(input logic dbl, input logic [1:0] rs);
      logic [7:0] d;
      d = DIV_NORM_0;
      case ({dbl, rs})
         3'h0: d = DIV_NORM_0;
         3'h1: d = DIV_NORM_1;
         3'h2: d = DIV_NORM_2;
         3'h3: d = DIV_NORM_3;
         3'h4: d = DIV_FAST_0;
         3'h5: d = DIV_FAST_1;
         3'h6: d = DIV_FAST_2;
         default: d = DIV_FAST_3;
      endcase
      return d[7:1];
   endfunction : half_div

endpackage : sfb_pkg

// ===== testbench/sfb_spi_buffers_props.sv
`timescale 1ns/10ps
`default_nettype none
module sfb_spi_buffers_props
(
   // clock, reset, bus
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   input wire logic [11:0] paddr_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   // interrupt and link
   input wire logic global_irq_enable_in,
   input wire logic irq_out,
   input wire logic serial_clock_pin_out,
   input wire logic mosi_out,
   input wire logic miso_in,
   input wire logic select_n_out
);
   logic [10:0] low_cnt_ff;
   logic [10:0] nxt_low_cnt;
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!reset_n_in);
   // frame length in system cycles; an abort would break this, the bench never aborts
   always_comb nxt_low_cnt = select_n_out ? 11'h000 : low_cnt_ff + 11'h001;
   always_ff @(posedge ref_clk_in or negedge reset_n_in)
      if (!reset_n_in)
         low_cnt_ff <= 11'h000;
      else
         low_cnt_ff <= nxt_low_cnt;
   a_ready_zero_wait: assert property (psel_in && penable_in |-> pready_out)
      else $error("pready missing in access phase");
   a_ready_only_access: assert property (pready_out |-> psel_in && penable_in)
      else $error("pready outside access phase");
   a_slverr_phase: assert property (pslverr_out |-> psel_in && penable_in)
      else $error("pslverr outside access phase");
   a_rdata_upper_zero: assert property (prdata_out[31:8] == 24'h000000)
      else $error("read data upper bits set");
   a_irq_global_gate: assert property (!global_irq_enable_in |-> !irq_out)
      else $error("interrupt without global enable");
   a_frame_min_len: assert property ($fell(select_n_out) |-> !select_n_out [*8])
      else $error("frame too short");
   a_frame_exact_len: assert property ($rose(select_n_out) |->
      low_cnt_ff inside {11'd16, 11'd32, 11'd64, 11'd128, 11'd256, 11'd512, 11'd1024})
      else $error("frame length not a divisor multiple");
   a_sck_quiet_idle: assert property ($changed(serial_clock_pin_out) |->
      !$past(select_n_out) || $past(psel_in && penable_in && pwrite_in, 2))
      else $error("serial clock moved while idle");
   c_frame: cover property ($rose(select_n_out));
   c_irq: cover property ($rose(irq_out));
   c_error: cover property (pslverr_out);
endmodule : sfb_spi_buffers_props
bind sfb_spi_buffers sfb_spi_buffers_props u_sfb_spi_buffers_props (.*);
`default_nettype wire

// ===== testbench/sfb_spi_peer.sv
`timescale 1ns/10ps
`default_nettype none
module sfb_spi_peer
(
   // serial link
   input wire logic sck_in,
   input wire logic mosi_in,
   input wire logic select_n_in,
   output logic miso_out,
   // bench side
   input wire logic [7:0] reply_in,
   output logic [7:0] got_out
);
   logic [7:0] sh;
   // mode 0 peer: shift out on trailing edges, capture on leading edges
   always @(negedge select_n_in) sh = reply_in;
   always @(negedge sck_in) if (!select_n_in) sh = {sh[6:0], 1'b0};
   always @(posedge sck_in) if (!select_n_in) got_out = {got_out[6:0], mosi_in};
   // no pull on the line, so a released peer shows the inverse rather than a stale bit
   assign miso_out = select_n_in ? ~sh[7] : sh[7];
endmodule : sfb_spi_peer
`default_nettype wire

// ===== testbench/tb_spi_rate_and_fifo_buffers.sv
`timescale 1ns/10ps
`default_nettype none
module tb_spi_rate_and_fifo_buffers;
   logic ref_clk_in, reset_n_in, psel, penable, pwrite, glb, miso, sck, mosi, sel_n, pready, pslverr, irq, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] reply, got;
   logic [7:0] divs [8] = '{8'h04, 8'h10, 8'h40, 8'h80, 8'h02, 8'h08, 8'h20, 8'h40};
   int miscompares = 0;
   int comparisons = 0;
   sfb_spi_buffers u_sfb_spi_buffers (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .paddr_in(paddr),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .global_irq_enable_in(glb), .irq_out(irq),
      .serial_clock_pin_out(sck), .mosi_out(mosi), .miso_in(miso), .select_n_out(sel_n));
   sfb_spi_peer u_sfb_spi_peer (.sck_in(sck), .mosi_in(mosi), .select_n_in(sel_n), .miso_out(miso),
      .reply_in(reply), .got_out(got));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge ref_clk_in);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= {24'h000000, d};
      @(posedge ref_clk_in);
      penable <= 1'b1;
      do
      begin
         @(posedge ref_clk_in);
         n++;
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic t_reset;
      apb(1'b0, sfb_pkg::IDX_BUF_STATUS, 8'h00);
      chk(rd, 32'h44);
      apb(1'b0, sfb_pkg::IDX_DATA, 8'h00);
      chk(rd, 32'h00);
      apb(1'b0, sfb_pkg::IDX_BUF_STATUS, 8'h00);
      chk(rd, 32'h54);
      apb(1'b1, sfb_pkg::IDX_BUF_STATUS, 8'h40);
      apb(1'b0, sfb_pkg::IDX_BUF_STATUS, 8'h00);
      chk(rd, 32'h44);
      apb(1'b0, 8'h3a, 8'h00);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      $display("reset test done");
   endtask : t_reset
   task automatic t_txfill;
      apb(1'b1, sfb_pkg::IDX_IRQ_MASK, 8'h04);
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b1, sfb_pkg::IDX_DATA, 8'h11);
         apb(1'b0, sfb_pkg::IDX_BUF_STATUS, 8'h00);
         chk(rd, (i == 3) ? 32'h48 : 32'h40 + i + 1);
      end
      chk(irq, 1'b1);
      apb(1'b1, sfb_pkg::IDX_DATA, 8'hff);
      apb(1'b0, sfb_pkg::IDX_STATUS, 8'h00);
      chk(rd[6], 1'b1);
      chk(rd[7], 1'b1);
      apb(1'b1, sfb_pkg::IDX_IRQ_STATUS, 8'h04);
      @(negedge ref_clk_in);
      chk(irq, 1'b0);
      apb(1'b1, sfb_pkg::IDX_BUF_STATUS, 8'h04);
      apb(1'b0, sfb_pkg::IDX_BUF_STATUS, 8'h00);
      chk(rd, 32'h44);
      $display("transmit fill test done");
   endtask : t_txfill
   task automatic t_xfer;
      int n;
      // start from a clean flag set so the first done proves the transfer event
      apb(1'b1, sfb_pkg::IDX_IRQ_STATUS, 8'h07);
      apb(1'b1, sfb_pkg::IDX_IRQ_MASK, 8'h01);
      chk(irq, 1'b0);
      for (int i = 0; i < 8; i++)
      begin
         apb(1'b1, sfb_pkg::IDX_STATUS, {7'h00, i[2]});
         apb(1'b1, sfb_pkg::IDX_CTRL, 8'hd0 | i[1:0]);
         reply <= 8'(8'h30 + i);
         apb(1'b1, sfb_pkg::IDX_DATA, 8'(8'ha0 + i));
         n = 0;
         while (sel_n !== 1'b0 && n < 64)
         begin
            @(negedge ref_clk_in);
            n++;
         end
         n = 0;
         while (sel_n === 1'b0 && n < 2048)
         begin
            @(negedge ref_clk_in);
            n++;
         end
         chk(n, {21'h0, divs[i], 3'h0});
         chk(got, 8'ha0 + i);
         if (i == 0)
         begin
            apb(1'b0, sfb_pkg::IDX_BUF_STATUS, 8'h00);
            chk(rd[6], 1'b0);
            chk(irq, 1'b1);
            glb <= 1'b0;
            @(negedge ref_clk_in);
            chk(irq, 1'b0);
            @(posedge ref_clk_in);
            glb <= 1'b1;
         end
         if (i == 3)
         begin
            apb(1'b0, sfb_pkg::IDX_BUF_STATUS, 8'h00);
            chk(rd, 32'h84);
            apb(1'b0, sfb_pkg::IDX_IRQ_STATUS, 8'h00);
            chk(rd[1:0], 2'h3);
            for (int j = 0; j < 4; j++)
            begin
               apb(1'b0, sfb_pkg::IDX_DATA, 8'h00);
               chk(rd, 32'h30 + j);
            end
         end
      end
      apb(1'b1, sfb_pkg::IDX_BUF_STATUS, 8'h44);
      apb(1'b0, sfb_pkg::IDX_BUF_STATUS, 8'h00);
      chk(rd, 32'h44);
      $display("transfer test done");
   endtask : t_xfer
   task automatic t_lsb;
      int n;
      // peer captures msb first, so an lsb-first byte arrives bit-reversed
      apb(1'b1, sfb_pkg::IDX_CTRL, 8'hf0);
      reply <= 8'h01;
      apb(1'b1, sfb_pkg::IDX_DATA, 8'h03);
      n = 0;
      while (sel_n !== 1'b0 && n < 64)
      begin
         @(negedge ref_clk_in);
         n++;
      end
      while (sel_n === 1'b0 && n < 2048)
      begin
         @(negedge ref_clk_in);
         n++;
      end
      chk(got, 8'hc0);
      apb(1'b0, sfb_pkg::IDX_DATA, 8'h00);
      chk(rd, 32'h80);
      $display("lsb first test done");
   endtask : t_lsb
   task automatic final_report;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : final_report
   initial
   begin
      ref_clk_in = 1'b0;
      forever #10 ref_clk_in = ~ref_clk_in;
   end
   initial
   begin
      #400000;
      miscompares++;
      final_report();
   end
   initial
   begin
      {reset_n_in, psel, penable, pwrite, paddr, pwdata, reply} = '0;
      glb = 1'b1;
      repeat (6) @(posedge ref_clk_in);
      reset_n_in <= 1'b1;
      t_reset();
      t_txfill();
      t_xfer();
      t_lsb();
      final_report();
   end
endmodule : tb_spi_rate_and_fifo_buffers
`default_nettype wire
